// ### shared/rdc_pkg.sv
/*
 * Constants and types for the redriver configuration register bank.
 * Assumes byte-wide register addressing from an external two-wire serial engine.
 */
package rdc_pkg;

  // Register sub-addresses
  localparam logic [7:0] RDC_OFS_GENERAL_CONTROL = 8'h0a;
  localparam logic [7:0] RDC_OFS_DP_EQ_LANES_ONE_THREE = 8'h10;
  localparam logic [7:0] RDC_OFS_DP_EQ_LANES_ZERO_TWO = 8'h11;
  localparam logic [7:0] RDC_OFS_DP_SNOOP_STATUS = 8'h12;
  localparam logic [7:0] RDC_OFS_DP_LANE_CONTROL = 8'h13;

  // General control fields
  localparam int RDC_GEN_CFG_LSB = 0;
  localparam int RDC_GEN_CFG_MSB = 1;
  localparam int RDC_GEN_SWAP_BIT = 2;
  localparam int RDC_GEN_DPSRC_BIT = 3;
  localparam int RDC_GEN_EQSRC_BIT = 4;
  localparam logic [4:0] RDC_GEN_RESET = 5'h01;

  // Snoop status fields
  localparam int RDC_SNP_LCNT_LSB = 0;
  localparam int RDC_SNP_LCNT_MSB = 4;
  localparam int RDC_SNP_PWR_LSB = 5;
  localparam int RDC_SNP_PWR_MSB = 6;

  // Lane control fields
  localparam int RDC_LCTL_OFF_LSB = 0;
  localparam int RDC_LCTL_OFF_MSB = 3;
  localparam int RDC_LCTL_SBU_LSB = 4;
  localparam int RDC_LCTL_SBU_MSB = 5;
  localparam int RDC_LCTL_SNOOPDIS_BIT = 7;
  localparam logic [7:0] RDC_LCTL_WMASK = 8'hbf;

  // Lane configuration codes
  localparam logic [1:0] RDC_CFG_OFF = 2'h0;
  localparam logic [1:0] RDC_CFG_USB = 2'h1;
  localparam logic [1:0] RDC_CFG_DP4 = 2'h2;
  localparam logic [1:0] RDC_CFG_DP2_USB = 2'h3;
  localparam logic [3:0] RDC_DP2_LANE_MASK = 4'h3;

  // Snooped sink addresses and values
  localparam logic [19:0] RDC_DPCD_POWER_STATE = 20'h00600;
  localparam logic [19:0] RDC_DPCD_LANE_COUNT = 20'h00101;
  localparam logic [1:0] RDC_PWR_ACTIVE = 2'h1;

  localparam int RDC_LANES = 4;
  localparam int RDC_EQ_W = 4;

  typedef enum logic [2:0] {
    RDC_ST_IDLE = 3'b001,
    RDC_ST_SUBADDR = 3'b010,
    RDC_ST_XFER = 3'b100
  } rdc_state_e;

  typedef struct packed {
    rdc_state_e st;
    logic [7:0] ptr;
    logic [7:0] rdata;
    logic rvalid;
    logic [4:0] gen;
    logic [7:0] lctl;
    logic [1:0] pwr;
    logic [4:0] lcnt;
    logic cfg_hi_d;
    logic [3:0] lane_en;
    logic usb_en;
  } rdc_main_s;

  typedef struct packed {
    logic [3:0] level;
  } rdc_lane_s;

endpackage : rdc_pkg

// ### rtl/rdc_lane_eq.sv
/*
 * One DisplayPort lane equalization field.
 * Assumes the strap code is already decoded and synchronous to ref_clk.
 */
module rdc_lane_eq
  import rdc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Control
  input wire logic eq_source_from_regs,
  input wire logic [RDC_EQ_W-1:0] strap_code,
  input wire logic wr_en,
  input wire logic [RDC_EQ_W-1:0] wr_data,
  // Field value
  output logic [RDC_EQ_W-1:0] eq_level
);

  rdc_lane_s s_r;
  rdc_lane_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (!eq_source_from_regs) begin
      // Software writes are overwritten by the strap image in pin mode
      s_nxt.level = strap_code;
    end else if (wr_en) begin
      s_nxt.level = wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign eq_level = s_r.level;

endmodule : rdc_lane_eq

// ### rtl/rdc_regs.sv
/*
 * Configuration and status register bank of a sink-side redriving crosspoint.
 * Assumes a byte-level serial engine outside that frames transactions, and
 * AUX snoop logic that presents decoded sink writes as one-cycle strobes.
 */
// What this block does
// - Reset loads 01 general, zeros at 10-12.
// - Bit 3 picks DP enable source.
// - Lane config decodes off, USB, DP4, DP2+USB.
// - Four 4-bit lane EQ fields, reset zero.
// - Pin mode: EQ fields follow strap pins.
// - Register mode: EQ follows software writes.
// - Capture snooped sink power state, read-only.
// - Upper config bit falling clears power state.
// - Capture snooped lane count, read-only.
// - Snoop on: enable only counted lanes.
// - Upper config bit falling clears lane count.
// - Snoop off: force-off bits clear lane enables.
// - Force-off ignored while snooping enabled.
// - Sub-address byte, then data, pointer advances.
// - Reads start at pointer, continue until stop.
module rdc_regs
  import rdc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Byte port from the serial engine
  input wire logic txn_start,
  input wire logic txn_read,
  input wire logic txn_stop,
  input wire logic wr_byte_valid,
  input wire logic [7:0] wr_byte,
  input wire logic rd_byte_req,
  output logic [7:0] rd_byte,
  output logic rd_byte_valid,
  // Pins
  input wire logic dp_request_pin,
  input wire logic [3:0] dp_eq_strap_pins,
  // AUX snoop
  input wire logic aux_wr_valid,
  input wire logic [19:0] aux_wr_addr,
  input wire logic [7:0] aux_wr_data,
  // Datapath control
  output logic [3:0] lane0_eq_level,
  output logic [3:0] lane1_eq_level,
  output logic [3:0] lane2_eq_level,
  output logic [3:0] lane3_eq_level,
  output logic [3:0] dp_lane_enable,
  output logic usb_enable,
  output logic orientation_swap,
  output logic [1:0] aux_sbu_override
);

  rdc_main_s s_r;
  rdc_main_s s_nxt;

  logic [RDC_EQ_W-1:0] eq_lvl [RDC_LANES];
  logic [RDC_LANES-1:0] eq_wr;
  logic [RDC_EQ_W-1:0] eq_wdat [RDC_LANES];
  logic reg_wr;
  logic [7:0] rd_mux;
  logic [1:0] lane_config_select;
  logic lane_config_upper_bit;
  logic eq_source_from_regs;
  logic dp_enable_source_sel;
  logic aux_snoop_disable;
  logic [3:0] lane_force_off;
  logic dp_active;
  logic [3:0] cfg_lanes;
  logic [3:0] snoop_lanes;
  logic [3:0] lane_en_calc;

  assign lane_config_select = s_r.gen[RDC_GEN_CFG_MSB:RDC_GEN_CFG_LSB];
  assign lane_config_upper_bit = lane_config_select[1];
  assign eq_source_from_regs = s_r.gen[RDC_GEN_EQSRC_BIT];
  assign dp_enable_source_sel = s_r.gen[RDC_GEN_DPSRC_BIT];
  assign aux_snoop_disable = s_r.lctl[RDC_LCTL_SNOOPDIS_BIT];
  assign lane_force_off = s_r.lctl[RDC_LCTL_OFF_MSB:RDC_LCTL_OFF_LSB];

  // A data byte is only a register write once the sub-address is in
  assign reg_wr = wr_byte_valid && !txn_stop && !txn_start && (s_r.st == RDC_ST_XFER);

  // Odd lanes live at 10h and even lanes at 11h;
  // lanes 0 and 1 take the high nibble, lanes 2 and 3 the low nibble.
  for (genvar i = 0; i < RDC_LANES; i++) begin : g_lane
    localparam logic [7:0] OFS = (i % 2 == 1) ? RDC_OFS_DP_EQ_LANES_ONE_THREE
                                              : RDC_OFS_DP_EQ_LANES_ZERO_TWO;
    localparam bit HI = (i < 2);
    assign eq_wr[i] = reg_wr && (s_r.ptr == OFS);
    assign eq_wdat[i] = HI ? wr_byte[7:4] : wr_byte[3:0];
    rdc_lane_eq u_eq (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .eq_source_from_regs(eq_source_from_regs),
      .strap_code(dp_eq_strap_pins),
      .wr_en(eq_wr[i]),
      .wr_data(eq_wdat[i]),
      .eq_level(eq_lvl[i])
    );
  end

  // Read image, reserved bits and unmapped addresses return zero
  always_comb begin
    rd_mux = 8'h00;
    case (s_r.ptr)
      RDC_OFS_GENERAL_CONTROL: rd_mux = {3'h0, s_r.gen};
      RDC_OFS_DP_EQ_LANES_ONE_THREE: rd_mux = {eq_lvl[1], eq_lvl[3]};
      RDC_OFS_DP_EQ_LANES_ZERO_TWO: rd_mux = {eq_lvl[0], eq_lvl[2]};
      RDC_OFS_DP_SNOOP_STATUS: rd_mux = {1'b0, s_r.pwr, s_r.lcnt};
      RDC_OFS_DP_LANE_CONTROL: rd_mux = s_r.lctl & RDC_LCTL_WMASK;
      default: rd_mux = 8'h00;
    endcase
  end

  // Lane enable derivation
  always_comb begin
    dp_active = dp_enable_source_sel ? dp_request_pin : lane_config_upper_bit;
    cfg_lanes = 4'h0;
    case (lane_config_select)
      RDC_CFG_OFF: cfg_lanes = 4'h0;
      RDC_CFG_USB: cfg_lanes = 4'h0;
      RDC_CFG_DP4: cfg_lanes = 4'hf;
      RDC_CFG_DP2_USB: cfg_lanes = RDC_DP2_LANE_MASK;
      default: cfg_lanes = 4'h0;
    endcase
    // Sink lane count 1, 2 or 4; anything else leaves the lanes powered down
    snoop_lanes = 4'h0;
    case (s_r.lcnt)
      5'h01: snoop_lanes = 4'h1;
      5'h02: snoop_lanes = 4'h3;
      5'h04: snoop_lanes = 4'hf;
      default: snoop_lanes = 4'h0;
    endcase
    if (s_r.pwr != RDC_PWR_ACTIVE) begin
      snoop_lanes = 4'h0;
    end
    if (aux_snoop_disable) begin
      lane_en_calc = cfg_lanes & ~lane_force_off;
    end else begin
      // Force-off bits have no say here
      lane_en_calc = cfg_lanes & snoop_lanes;
    end
    if (!dp_active) begin
      lane_en_calc = 4'h0;
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    s_nxt.cfg_hi_d = lane_config_upper_bit;
    s_nxt.lane_en = lane_en_calc;
    s_nxt.usb_en = (lane_config_select == RDC_CFG_USB)
                || (lane_config_select == RDC_CFG_DP2_USB);

    // Snoop capture; a falling upper config bit clears, a same-cycle capture wins
    if (s_r.cfg_hi_d && !lane_config_upper_bit) begin
      s_nxt.pwr = 2'h0;
      s_nxt.lcnt = 5'h00;
    end
    if (aux_wr_valid && aux_wr_addr == RDC_DPCD_POWER_STATE) begin
      s_nxt.pwr = aux_wr_data[1:0];
    end
    if (aux_wr_valid && aux_wr_addr == RDC_DPCD_LANE_COUNT) begin
      s_nxt.lcnt = aux_wr_data[4:0];
    end

    // Byte port sequencing; stop beats start beats a byte
    case (s_r.st)
      RDC_ST_IDLE: begin
        if (txn_start && !txn_stop) begin
          s_nxt.st = txn_read ? RDC_ST_XFER : RDC_ST_SUBADDR;
        end
      end
      RDC_ST_SUBADDR: begin
        if (txn_stop) begin
          s_nxt.st = RDC_ST_IDLE;
        end else if (txn_start) begin
          s_nxt.st = txn_read ? RDC_ST_XFER : RDC_ST_SUBADDR;
        end else if (wr_byte_valid) begin
          s_nxt.ptr = wr_byte;
          s_nxt.st = RDC_ST_XFER;
        end
      end
      RDC_ST_XFER: begin
        if (txn_stop) begin
          s_nxt.st = RDC_ST_IDLE;
        end else if (txn_start) begin
          s_nxt.st = txn_read ? RDC_ST_XFER : RDC_ST_SUBADDR;
        end else if (wr_byte_valid) begin
          case (s_r.ptr)
            RDC_OFS_GENERAL_CONTROL: s_nxt.gen = wr_byte[4:0];
            RDC_OFS_DP_LANE_CONTROL: s_nxt.lctl = wr_byte & RDC_LCTL_WMASK;
            default: s_nxt.gen = s_r.gen;
          endcase
          s_nxt.ptr = s_r.ptr + 8'h01;
        end else if (rd_byte_req) begin
          s_nxt.rdata = rd_mux;
          s_nxt.rvalid = 1'b1;
          s_nxt.ptr = s_r.ptr + 8'h01;
        end
      end
      default: s_nxt.st = RDC_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_r.st <= RDC_ST_IDLE;
      s_r.ptr <= 8'h00;
      s_r.rdata <= 8'h00;
      s_r.rvalid <= 1'b0;
      s_r.gen <= RDC_GEN_RESET;
      s_r.lctl <= 8'h00;
      s_r.pwr <= 2'h0;
      s_r.lcnt <= 5'h00;
      s_r.cfg_hi_d <= 1'b0;
      s_r.lane_en <= 4'h0;
      s_r.usb_en <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rd_byte = s_r.rdata;
  assign rd_byte_valid = s_r.rvalid;
  assign lane0_eq_level = eq_lvl[0];
  assign lane1_eq_level = eq_lvl[1];
  assign lane2_eq_level = eq_lvl[2];
  assign lane3_eq_level = eq_lvl[3];
  assign dp_lane_enable = s_r.lane_en;
  assign usb_enable = s_r.usb_en;
  assign orientation_swap = s_r.gen[RDC_GEN_SWAP_BIT];
  assign aux_sbu_override = s_r.lctl[RDC_LCTL_SBU_MSB:RDC_LCTL_SBU_LSB];

endmodule : rdc_regs

// ### dv/rdc_regs_sva.sv
/* Port checker for rdc_regs.
   Bound to every rdc_regs instance; one clock domain, sync reset. */
module rdc_regs_sva
  import rdc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Byte port
  input wire logic txn_start,
  input wire logic txn_read,
  input wire logic txn_stop,
  input wire logic wr_byte_valid,
  input wire logic rd_byte_req,
  input wire logic [7:0] rd_byte,
  input wire logic rd_byte_valid,
  // Pins and datapath control
  input wire logic [3:0] dp_eq_strap_pins,
  input wire logic [3:0] lane0_eq_level,
  input wire logic [3:0] lane1_eq_level,
  input wire logic [3:0] lane2_eq_level,
  input wire logic [3:0] lane3_eq_level,
  input wire logic [3:0] dp_lane_enable,
  input wire logic usb_enable,
  input wire logic orientation_swap,
  input wire logic [1:0] aux_sbu_override
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // A stop in the gap would close the read, so the gap must be quiet
  sequence s_rd_open;
    txn_start && txn_read ##1 !txn_stop && !txn_start
      ##1 rd_byte_req && !txn_stop && !txn_start;
  endsequence
  a_reset_vals: assert property ($fell(sys_rst) |->
    dp_lane_enable == 4'h0 && !usb_enable && !orientation_swap && rd_byte == 8'h00)
    else $error("outputs wrong after reset");
  a_rd_answer: assert property (s_rd_open |=> rd_byte_valid)
    else $error("read request not answered");
  a_rd_cause: assert property (rd_byte_valid |-> $past(rd_byte_req))
    else $error("read data without request");
  a_stop_no_rd: assert property (txn_stop |=> !rd_byte_valid)
    else $error("read data after stop");
  a_rd_hold: assert property (!rd_byte_valid |-> $stable(rd_byte))
    else $error("read data changed without a read");
  a_usb_dp_excl: assert property (!(usb_enable && |dp_lane_enable[3:2]))
    else $error("usb on with upper dp lanes");
  a_eq_after_rst: assert property ($fell(sys_rst) |=>
    {lane0_eq_level, lane1_eq_level, lane2_eq_level, lane3_eq_level}
      == {4{$past(dp_eq_strap_pins)}})
    else $error("eq fields not following straps");
  a_swap_by_write: assert property (
    $changed({orientation_swap, aux_sbu_override}) |-> $past(wr_byte_valid))
    else $error("control bit changed without a write");
endmodule : rdc_regs_sva

bind rdc_regs rdc_regs_sva i_sva (
  .ref_clk(ref_clk),
  .sys_rst(sys_rst),
  .txn_start(txn_start),
  .txn_read(txn_read),
  .txn_stop(txn_stop),
  .wr_byte_valid(wr_byte_valid),
  .rd_byte_req(rd_byte_req),
  .rd_byte(rd_byte),
  .rd_byte_valid(rd_byte_valid),
  .dp_eq_strap_pins(dp_eq_strap_pins),
  .lane0_eq_level(lane0_eq_level),
  .lane1_eq_level(lane1_eq_level),
  .lane2_eq_level(lane2_eq_level),
  .lane3_eq_level(lane3_eq_level),
  .dp_lane_enable(dp_lane_enable),
  .usb_enable(usb_enable),
  .orientation_swap(orientation_swap),
  .aux_sbu_override(aux_sbu_override)
);

// ### dv/rdc_host.sv
/* Serial-engine host and AUX snoop source for rdc_regs.
   Drives on falling edges; the bench calls its tasks. */
module rdc_host
  import rdc_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Byte port
  output logic txn_start,
  output logic txn_read,
  output logic txn_stop,
  output logic wr_byte_valid,
  output logic [7:0] wr_byte,
  output logic rd_byte_req,
  input wire logic [7:0] rd_byte,
  input wire logic rd_byte_valid,
  // AUX snoop
  output logic aux_wr_valid,
  output logic [19:0] aux_wr_addr,
  output logic [7:0] aux_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {txn_start, txn_read, txn_stop, rd_byte_req} = 4'h0;
    {wr_byte_valid, wr_byte, aux_wr_valid, aux_wr_addr, aux_wr_data} = '0;
  end
  // Every strobe waits for a fresh falling edge, so no signal moves twice in one step
  task automatic start(input logic rd);
    @(negedge ref_clk);
    txn_read = rd;
    txn_start = 1'b1;
    @(negedge ref_clk);
    txn_start = 1'b0;
  endtask : start
  task automatic stop();
    @(negedge ref_clk);
    txn_stop = 1'b1;
    @(negedge ref_clk);
    txn_stop = 1'b0;
  endtask : stop
  // Released data is inverted so a stale byte never looks live
  task automatic put(input logic [7:0] b);
    @(negedge ref_clk);
    wr_byte = b;
    wr_byte_valid = 1'b1;
    @(negedge ref_clk);
    wr_byte_valid = 1'b0;
    wr_byte = ~b;
  endtask : put
  // A missing answer hands back unknowns so the caller's compare trips
  task automatic fetch(output logic [7:0] d);
    @(negedge ref_clk);
    rd_byte_req = 1'b1;
    @(negedge ref_clk);
    rd_byte_req = 1'b0;
    for (int i = 0; i < 3 && rd_byte_valid !== 1'b1; i++) @(negedge ref_clk);
    d = (rd_byte_valid === 1'b1) ? rd_byte : 8'hxx;
  endtask : fetch
  task automatic snoop(input logic [19:0] a, input logic [7:0] v);
    @(negedge ref_clk);
    aux_wr_addr = a;
    aux_wr_data = v;
    aux_wr_valid = 1'b1;
    @(negedge ref_clk);
    aux_wr_valid = 1'b0;
    aux_wr_addr = ~a;
    aux_wr_data = ~v;
  endtask : snoop
endmodule : rdc_host

// ### dv/test_redriver_config_regs.sv
/* Self-checking bench for rdc_regs with the host model.
   Checker is bound from its own file. */
module test_redriver_config_regs
  import rdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, sys_rst = 1'b1, dp_request_pin = 1'b0;
  logic [3:0] dp_eq_strap_pins = 4'h0;
  logic txn_start, txn_read, txn_stop, wr_byte_valid, rd_byte_req, rd_byte_valid;
  logic aux_wr_valid, usb_enable, orientation_swap;
  logic [7:0] wr_byte, rd_byte, aux_wr_data, d;
  logic [19:0] aux_wr_addr;
  logic [3:0] lane0_eq_level, lane1_eq_level, lane2_eq_level, lane3_eq_level, dp_lane_enable;
  logic [1:0] aux_sbu_override;
  int error_cnt = 0, comparisons = 0, cyc = 0;
  // Address, write data, expected readback
  logic [23:0] rows [7] = '{24'h0aff1f, 24'h10a5a5, 24'h113c3c, 24'h12ff00,
    24'h137f3f, 24'h30ff00, 24'h0a0101};
  initial forever #20 ref_clk = ~ref_clk;
  rdc_regs i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst),
    .txn_start(txn_start), .txn_read(txn_read), .txn_stop(txn_stop),
    .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte),
    .rd_byte_req(rd_byte_req), .rd_byte(rd_byte), .rd_byte_valid(rd_byte_valid),
    .dp_request_pin(dp_request_pin), .dp_eq_strap_pins(dp_eq_strap_pins),
    .aux_wr_valid(aux_wr_valid), .aux_wr_addr(aux_wr_addr), .aux_wr_data(aux_wr_data),
    .lane0_eq_level(lane0_eq_level), .lane1_eq_level(lane1_eq_level),
    .lane2_eq_level(lane2_eq_level), .lane3_eq_level(lane3_eq_level),
    .dp_lane_enable(dp_lane_enable), .usb_enable(usb_enable),
    .orientation_swap(orientation_swap), .aux_sbu_override(aux_sbu_override)
  );
  rdc_host i_host (
    .ref_clk(ref_clk),
    .txn_start(txn_start), .txn_read(txn_read), .txn_stop(txn_stop),
    .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte),
    .rd_byte_req(rd_byte_req), .rd_byte(rd_byte), .rd_byte_valid(rd_byte_valid),
    .aux_wr_valid(aux_wr_valid), .aux_wr_addr(aux_wr_addr), .aux_wr_data(aux_wr_data)
  );
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_host.start(1'b0);
    i_host.put(a);
    i_host.put(v);
    i_host.stop();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    i_host.start(1'b0);
    i_host.put(a);
    i_host.stop();
    i_host.start(1'b1);
    i_host.fetch(v);
    i_host.stop();
  endtask : rd
  task automatic lanes(input logic [3:0] e);
    repeat (2) @(negedge ref_clk);
    chk("lanes", {4'h0, e}, {4'h0, dp_lane_enable});
  endtask : lanes
  task automatic print_verdict();
    $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    repeat (3) @(negedge ref_clk);
    sys_rst = 1'b0;
    i_host.start(1'b1);
    i_host.fetch(d);
    i_host.stop();
    chk("first", 8'h00, d);
    for (int i = 0; i < 4; i++) begin
      rd(8'h10 + 8'(i), d);
      chk("dp reset", 8'h00, d);
    end
    chk("usb", 8'h01, {7'h0, usb_enable});
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], d);
      chk("row", rows[i][7:0], d);
    end
    chk("sbu", 8'h03, {6'h0, aux_sbu_override});
    dp_eq_strap_pins = 4'h9;
    repeat (2) @(negedge ref_clk);
    chk("eq", 8'h99, {lane0_eq_level, lane2_eq_level});
    chk("eq", 8'h99, {lane1_eq_level, lane3_eq_level});
    wr(8'h0a, 8'h15);
    wr(8'h10, 8'h7e);
    dp_eq_strap_pins = 4'h2;
    repeat (2) @(negedge ref_clk);
    chk("eq", 8'h7e, {lane1_eq_level, lane3_eq_level});
    chk("eq", 8'h99, {lane0_eq_level, lane2_eq_level});
    chk("swap", 8'h01, {7'h0, orientation_swap});
    i_host.start(1'b0);
    i_host.put(8'h10);
    i_host.put(8'h12);
    i_host.put(8'h34);
    i_host.stop();
    i_host.start(1'b0);
    i_host.put(8'h10);
    i_host.stop();
    i_host.start(1'b1);
    i_host.fetch(d);
    chk("burst", 8'h12, d);
    i_host.fetch(d);
    chk("burst", 8'h34, d);
    i_host.fetch(d);
    i_host.stop();
    chk("status", 8'h00, d);
    wr(8'h0a, 8'h02);
    i_host.snoop(RDC_DPCD_POWER_STATE, 8'h01);
    i_host.snoop(RDC_DPCD_LANE_COUNT, 8'h02);
    lanes(4'h3);
    i_host.snoop(RDC_DPCD_LANE_COUNT, 8'h04);
    lanes(4'hf);
    rd(8'h12, d);
    chk("snoop", 8'h24, d);
    i_host.snoop(RDC_DPCD_POWER_STATE, 8'h02);
    lanes(4'h0);
    wr(8'h0a, 8'h01);
    rd(8'h12, d);
    chk("snoop", 8'h00, d);
    wr(8'h13, 8'h85);
    wr(8'h0a, 8'h02);
    lanes(4'ha);
    wr(8'h13, 8'h80);
    for (int c = 0; c < 4; c++) begin
      wr(8'h0a, {6'h0, c[1:0]});
      lanes(c == 2 ? 4'hf : c == 3 ? 4'h3 : 4'h0);
      chk("usb", {7'h0, c[0]}, {7'h0, usb_enable});
    end
    wr(8'h0a, 8'h0a);
    lanes(4'h0);
    dp_request_pin = 1'b1;
    lanes(4'hf);
    // Reset again with non-default contents to see general control, lane control and lane enables return home
    sys_rst = 1'b1;
    repeat (3) @(negedge ref_clk);
    sys_rst = 1'b0;
    rd(8'h0a, d);
    chk("gen reset", 8'h01, d);
    rd(8'h13, d);
    chk("lctl reset", 8'h00, d);
    lanes(4'h0);
    print_verdict();
  end
endmodule : test_redriver_config_regs
